// File: limit_flags_pkg.sv
// Package: register map, field positions and reset values of the limit status flags
// How it works
// - Both status registers reset to zero and ignore host writes.
// - A host read clears a latched bit only if its condition has gone.
// - Rail out of limit sets primary bits 0 to 3 and secondary bit 0.
// - With the shared pin in thermal mode, primary bit 0 flags timer overrun.
// - Primary bit 4 flags the first remote temperature out of limit.
// - Primary bit 5 flags the local temperature out of limit.
// - Primary bit 6 flags the second remote temperature out of limit.
// - Primary bit 7 is the OR of all secondary register bits.
// - Secondary bit 1 is the OR of the third status register.
// - Secondary bits 2 to 4 flag fans one to three slow or stalled.
// - A fan flag is never set while its drive output is off.
// - In tach mode secondary bit 5 flags fan four, suppressed by drive three off.
// - In thermal timer mode secondary bit 5 flags timer limit exceeded.
// - Secondary bit 6 flags an open or short first diode.
// - Secondary bit 7 flags an open or short second diode.
// - High violation is reading above limit; low violation is reading at or below.
package limit_flags_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PRIMARY    = 8'h41;
  localparam logic [7:0]  IDX_SECONDARY  = 8'h42;
  localparam logic [11:0] ADDR_PRIMARY   = {2'h0, IDX_PRIMARY, 2'h0};
  localparam logic [11:0] ADDR_SECONDARY = {2'h0, IDX_SECONDARY, 2'h0};
  localparam logic [11:0] ADDR_CONFIG    = 12'h110;
  localparam logic [11:0] ADDR_IRQ_STAT  = 12'h114;
  localparam logic [11:0] ADDR_IRQ_MASK  = 12'h118;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [1:0]  CONFIG_RESET   = 2'h0;
  localparam logic [15:0] IRQ_RESET      = 16'h0000;
  // Config fields
  localparam int CFG_PRI_THERMAL = 0;
  localparam int CFG_SEC_THERMAL = 1;
  // Primary fields
  localparam int PRI_RAIL_LO   = 0;
  localparam int PRI_RAIL_HI   = 3;
  localparam int PRI_REMOTE1   = 4;
  localparam int PRI_LOCAL     = 5;
  localparam int PRI_REMOTE2   = 6;
  localparam int PRI_SUMMARY   = 7;
  // Secondary fields
  localparam int SEC_RAIL5     = 0;
  localparam int SEC_SUMMARY   = 1;
  localparam int SEC_TACH_ONE  = 2;
  localparam int SEC_TACH_FOUR = 5;
  localparam int SEC_DIODE1    = 6;
  localparam int SEC_DIODE2    = 7;
  // Measurement channels: 0..4 rails, 5 remote one, 6 local, 7 remote two
  localparam int CH_RAIL5      = 4;
  localparam int CH_TEMP_FIRST = 5;
  localparam int CH_NUM        = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : limit_flags_pkg

// File: monitor_limit_status_flags.sv
// Module: latched out-of-limit status registers with AXI4-Lite access and interrupt
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module monitor_limit_status_flags #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic                                          clk_sys,
  input  wire logic                                          sys_rst,
  // Measurement results, one done pulse per channel
  input  wire logic [limit_flags_pkg::CH_NUM-1:0]             meas_done,
  input  wire logic [limit_flags_pkg::CH_NUM-1:0][DATA_W-1:0] meas_reading,
  input  wire logic [limit_flags_pkg::CH_NUM-1:0][DATA_W-1:0] limit_low,
  input  wire logic [limit_flags_pkg::CH_NUM-1:0][DATA_W-1:0] limit_high,
  // Fan, thermal timer and diode conditions (levels)
  input  wire logic [3:0]                                     tach_slow,
  input  wire logic [2:0]                                     fan_drive_off,
  input  wire logic                                           thermal_timer_over,
  input  wire logic [1:0]                                     diode_fault,
  input  wire logic                                           tertiary_any,
  // AXI4-Lite slave
  input  wire logic                                           s_axi_awvalid,
  output logic                                                s_axi_awready,
  input  wire logic [11:0]                                    s_axi_awaddr,
  input  wire logic                                           s_axi_wvalid,
  output logic                                                s_axi_wready,
  input  wire logic [31:0]                                    s_axi_wdata,
  input  wire logic [3:0]                                     s_axi_wstrb,
  output logic                                                s_axi_bvalid,
  input  wire logic                                           s_axi_bready,
  output logic [1:0]                                          s_axi_bresp,
  input  wire logic                                           s_axi_arvalid,
  output logic                                                s_axi_arready,
  input  wire logic [11:0]                                    s_axi_araddr,
  output logic                                                s_axi_rvalid,
  input  wire logic                                           s_axi_rready,
  output logic [31:0]                                         s_axi_rdata,
  output logic [1:0]                                          s_axi_rresp,
  // Interrupt
  output logic                                                irq
);

  if (DATA_W < 2 || DATA_W > 16)
  begin : g_bad_width
    $error("DATA_W must lie between 2 and 16");
  end

  typedef struct packed {
    logic [7:0]  pri;
    logic [7:0]  sec;
    logic [limit_flags_pkg::CH_NUM-1:0] viol;
    logic [1:0]  cfg;
    logic [15:0] irq_st;
    logic [15:0] irq_mask;
    logic        aw_have;
    logic [11:0] aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Per-channel window comparison
  logic [limit_flags_pkg::CH_NUM-1:0] viol_now;
  for (genvar c = 0; c < limit_flags_pkg::CH_NUM; c++)
  begin : g_cmp
    if (c >= limit_flags_pkg::CH_TEMP_FIRST)
    begin : g_signed
      assign viol_now[c] = ($signed(meas_reading[c]) > $signed(limit_high[c])) ||
                           ($signed(meas_reading[c]) <= $signed(limit_low[c]));
    end
    else
    begin : g_unsigned
      assign viol_now[c] = (meas_reading[c] > limit_high[c]) ||
                           (meas_reading[c] <= limit_low[c]);
    end
  end

  logic [7:0]  pri_cond;
  logic [7:0]  sec_cond;
  logic [7:0]  pri_mask;
  logic [7:0]  sec_mask;
  logic [15:0] flags_new;
  logic        rd_pri;
  logic        rd_sec;
  logic        w_fire;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  logic [7:0]  pri_view;
  logic [7:0]  sec_view;

  // Readies drop while a write is held, so only one write is in flight
  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign irq           = |(s_q.irq_st & s_q.irq_mask);

  // Summary bits are live ORs, not latches
  assign sec_view = {s_q.sec[7:2], tertiary_any, s_q.sec[0]};
  assign pri_view = {|sec_view, s_q.pri[6:0]};

  always_comb
  begin
    s_d = s_q;
    // Violation state follows every completed measurement
    for (int c = 0; c < limit_flags_pkg::CH_NUM; c++)
    begin
      if (meas_done[c])
      begin
        s_d.viol[c] = viol_now[c];
      end
    end
    // Present conditions and new set requests
    pri_cond = 8'h00;
    sec_cond = 8'h00;
    pri_mask = 8'h00;
    sec_mask = 8'h00;
    pri_cond[limit_flags_pkg::PRI_RAIL_HI:1] = s_d.viol[3:1];
    pri_cond[0] = s_q.cfg[limit_flags_pkg::CFG_PRI_THERMAL] ?
                  thermal_timer_over : s_d.viol[0];
    pri_cond[limit_flags_pkg::PRI_REMOTE1] = s_d.viol[5];
    pri_cond[limit_flags_pkg::PRI_LOCAL]   = s_d.viol[6];
    pri_cond[limit_flags_pkg::PRI_REMOTE2] = s_d.viol[7];
    sec_cond[limit_flags_pkg::SEC_RAIL5] = s_d.viol[limit_flags_pkg::CH_RAIL5];
    sec_cond[4:2] = tach_slow[2:0] & ~fan_drive_off;
    sec_cond[limit_flags_pkg::SEC_TACH_FOUR] = s_q.cfg[limit_flags_pkg::CFG_SEC_THERMAL] ?
      thermal_timer_over : (tach_slow[3] && !fan_drive_off[2]);
    sec_cond[limit_flags_pkg::SEC_DIODE1] = diode_fault[0];
    sec_cond[limit_flags_pkg::SEC_DIODE2] = diode_fault[1];
    // Voltage and temperature bits set only on a measurement edge
    pri_mask[6:1] = meas_done[7:5] == 3'h0 && meas_done[3:1] == 3'h0 ? 6'h00 :
                    {meas_done[7:5], meas_done[3:1]};
    // In thermal mode bit 0 is set by the timer level on every cycle
    pri_mask[0]   = s_q.cfg[limit_flags_pkg::CFG_PRI_THERMAL] ? 1'b1 : meas_done[0];
    sec_mask      = {7'h7E, meas_done[limit_flags_pkg::CH_RAIL5]};
    sec_mask[limit_flags_pkg::SEC_SUMMARY] = 1'b0;
    // Read clears only bits whose condition has gone; set wins
    rd_pri = s_axi_arvalid && s_axi_arready && s_axi_araddr == limit_flags_pkg::ADDR_PRIMARY;
    rd_sec = s_axi_arvalid && s_axi_arready && s_axi_araddr == limit_flags_pkg::ADDR_SECONDARY;
    s_d.pri = (s_q.pri & ~({8{rd_pri}} & ~pri_cond)) | (pri_cond & pri_mask);
    s_d.sec = (s_q.sec & ~({8{rd_sec}} & ~sec_cond)) | (sec_cond & sec_mask);
    s_d.pri[limit_flags_pkg::PRI_SUMMARY] = 1'b0;
    s_d.sec[limit_flags_pkg::SEC_SUMMARY] = 1'b0;
    flags_new = {s_d.sec & ~s_q.sec, s_d.pri & ~s_q.pri};
    // Write channel
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    w_fire = s_q.aw_have && s_q.w_have;
    s_d.irq_st = s_q.irq_st;
    if (w_fire)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = limit_flags_pkg::RESP_OKAY;
      if (s_q.aw_addr == limit_flags_pkg::ADDR_CONFIG)
      begin
        if (s_q.w_strb[0])
        begin
          s_d.cfg = s_q.w_data[1:0];
        end
      end
      else if (s_q.aw_addr == limit_flags_pkg::ADDR_IRQ_STAT)
      begin
        if (s_q.w_strb[0])
        begin
          s_d.irq_st[7:0] = s_q.irq_st[7:0] & ~s_q.w_data[7:0];
        end
        if (s_q.w_strb[1])
        begin
          s_d.irq_st[15:8] = s_q.irq_st[15:8] & ~s_q.w_data[15:8];
        end
      end
      else if (s_q.aw_addr == limit_flags_pkg::ADDR_IRQ_MASK)
      begin
        if (s_q.w_strb[0])
        begin
          s_d.irq_mask[7:0] = s_q.w_data[7:0];
        end
        if (s_q.w_strb[1])
        begin
          s_d.irq_mask[15:8] = s_q.w_data[15:8];
        end
      end
      else if (s_q.aw_addr == limit_flags_pkg::ADDR_PRIMARY ||
               s_q.aw_addr == limit_flags_pkg::ADDR_SECONDARY)
      begin
        s_d.bresp = limit_flags_pkg::RESP_OKAY;
      end
      else
      begin
        s_d.bresp = limit_flags_pkg::RESP_SLVERR;
      end
    end
    s_d.irq_st = s_d.irq_st | flags_new;
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // Read channel
    rd_word = 32'h0000_0000;
    rd_resp = limit_flags_pkg::RESP_OKAY;
    if (s_axi_araddr == limit_flags_pkg::ADDR_PRIMARY)
    begin
      rd_word[7:0] = pri_view;
    end
    else if (s_axi_araddr == limit_flags_pkg::ADDR_SECONDARY)
    begin
      rd_word[7:0] = sec_view;
    end
    else if (s_axi_araddr == limit_flags_pkg::ADDR_CONFIG)
    begin
      rd_word[1:0] = s_q.cfg;
    end
    else if (s_axi_araddr == limit_flags_pkg::ADDR_IRQ_STAT)
    begin
      rd_word[15:0] = s_q.irq_st;
    end
    else if (s_axi_araddr == limit_flags_pkg::ADDR_IRQ_MASK)
    begin
      rd_word[15:0] = s_q.irq_mask;
    end
    else
    begin
      rd_resp = limit_flags_pkg::RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = rd_resp;
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q          <= '0;
      s_q.pri      <= limit_flags_pkg::STATUS_RESET;
      s_q.sec      <= limit_flags_pkg::STATUS_RESET;
      s_q.cfg      <= limit_flags_pkg::CONFIG_RESET;
      s_q.irq_st   <= limit_flags_pkg::IRQ_RESET;
      s_q.irq_mask <= limit_flags_pkg::IRQ_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  clear_gone_a: assert property (rd_pri && !pri_cond[1] |=> !s_q.pri[1])
    else $error("primary bit not cleared by read after condition gone");
  hold_present_a: assert property (s_q.sec[6] && diode_fault[0] |=> s_q.sec[6])
    else $error("diode flag dropped while fault present");
  rail_set_a: assert property (meas_done[2] && viol_now[2] |=> s_q.pri[2])
    else $error("rail violation did not set flag");
  thermal_mode_a: assert property (s_q.cfg[0] && thermal_timer_over |=> s_q.pri[0])
    else $error("thermal overrun did not set primary bit 0");
  remote_one_a: assert property (meas_done[5] && viol_now[5] |=> s_q.pri[4])
    else $error("remote one violation lost");
  local_temp_a: assert property (meas_done[6] && viol_now[6] |=> s_q.pri[5])
    else $error("local violation lost");
  remote_two_a: assert property (meas_done[7] && viol_now[7] |=> s_q.pri[6])
    else $error("remote two violation lost");
  summary_or_a: assert property (rd_pri |-> rd_word[7] == (tertiary_any || (|s_q.sec)))
    else $error("primary summary does not match secondary");
  tert_or_a: assert property (rd_sec |-> rd_word[1] == tertiary_any)
    else $error("secondary summary does not match tertiary");
  fan_off_a: assert property (fan_drive_off[0] && !s_q.sec[2] |=> !s_q.sec[2])
    else $error("fan flag set while drive off");
  fan_set_a: assert property (tach_slow[1] && !fan_drive_off[1] |=> s_q.sec[3])
    else $error("fan two slow not flagged");
  read_only_a: assert property (w_fire && s_q.aw_addr == limit_flags_pkg::ADDR_PRIMARY
    && !s_q.pri[3] && !pri_cond[3] |=> !s_q.pri[3])
    else $error("status changed by host write");
  set_wins_a: assert property (rd_sec && diode_fault[1] |=> s_q.sec[7])
    else $error("set lost to clearing read");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");

  // Rails, temperatures and the limit compare
  rail_one_a: assert property (meas_done[1] && viol_now[1] |=> s_q.pri[1])
    else $error("second rail violation did not set flag");
  rail_three_a: assert property (meas_done[3] && viol_now[3] |=> s_q.pri[3])
    else $error("fourth rail violation did not set flag");
  rail_five_a: assert property (meas_done[4] && viol_now[4] |=> s_q.sec[0])
    else $error("fifth rail violation did not set flag");
  rail_zero_a: assert property (!s_q.cfg[0] && meas_done[0] && viol_now[0] |=> s_q.pri[0])
    else $error("first rail violation did not set flag");
  high_strict_a: assert property (meas_done[1] && meas_reading[1] == limit_high[1]
    && meas_reading[1] > limit_low[1] |=> !s_q.viol[1])
    else $error("reading equal to high limit flagged");
  low_equal_a: assert property (meas_done[2] && meas_reading[2] == limit_low[2] |=> s_q.viol[2])
    else $error("reading equal to low limit not flagged");
  temp_low_a: assert property (meas_done[5] && meas_reading[5] == limit_low[5] |=> s_q.viol[5])
    else $error("temperature at low limit not flagged");
  temp_high_a: assert property (meas_done[7] && $signed(meas_reading[7]) > $signed(limit_high[7])
    |=> s_q.pri[6])
    else $error("temperature above high limit not flagged");
  viol_hold_a: assert property (!meas_done[3] |=> $stable(s_q.viol[3]))
    else $error("violation state changed without a measurement");

  // Fans, thermal timer and diodes
  fan_one_a: assert property (tach_slow[0] && !fan_drive_off[0] |=> s_q.sec[2])
    else $error("fan one slow not flagged");
  fan_three_a: assert property (tach_slow[2] && !fan_drive_off[2] |=> s_q.sec[4])
    else $error("fan three slow not flagged");
  fan_two_off_a: assert property (fan_drive_off[1] && !s_q.sec[3] |=> !s_q.sec[3])
    else $error("fan two flag set while drive off");
  fan_three_off_a: assert property (fan_drive_off[2] && !s_q.sec[4] |=> !s_q.sec[4])
    else $error("fan three flag set while drive off");
  fan_four_a: assert property (!s_q.cfg[1] && tach_slow[3] && !fan_drive_off[2] |=> s_q.sec[5])
    else $error("fan four slow not flagged");
  fan_four_off_a: assert property (!s_q.cfg[1] && fan_drive_off[2] && !s_q.sec[5] |=> !s_q.sec[5])
    else $error("fan four flag set while drive three off");
  timer_four_a: assert property (s_q.cfg[1] && thermal_timer_over |=> s_q.sec[5])
    else $error("thermal timer overrun did not set secondary bit 5");
  diode_one_a: assert property (diode_fault[0] |=> s_q.sec[6])
    else $error("first diode fault not flagged");
  diode_two_a: assert property (diode_fault[1] |=> s_q.sec[7])
    else $error("second diode fault not flagged");

  // Read clear, write protection and set priority
  clear_sec_a: assert property (rd_sec && !sec_cond[6] |=> !s_q.sec[6])
    else $error("secondary bit not cleared by read after condition gone");
  clear_rail_a: assert property (rd_pri && !pri_cond[2] |=> !s_q.pri[2])
    else $error("rail bit not cleared by read after condition gone");
  sec_write_a: assert property (w_fire && s_q.aw_addr == limit_flags_pkg::ADDR_SECONDARY
    && !s_q.sec[6] && !diode_fault[0] |=> !s_q.sec[6])
    else $error("secondary status changed by host write");
  set_wins_pri_a: assert property (rd_pri && meas_done[6] && viol_now[6] |=> s_q.pri[5])
    else $error("local violation lost to clearing read");

  // Bus handshake and interrupt
  irq_sets_a: assert property (!s_q.sec[6] && diode_fault[0] |=> s_q.irq_st[14])
    else $error("interrupt status missed a rising flag");
  mask_irq_a: assert property (s_q.irq_mask == 16'h0000 |-> !irq)
    else $error("interrupt raised with all sources masked");
  write_answer_a: assert property (w_fire |=> s_axi_bvalid)
    else $error("write answer missing");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before it was taken");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before it was taken");
  read_slverr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0FC
    |=> s_axi_rresp == limit_flags_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  read_clear_c: cover property (rd_pri && s_q.pri[1] ##1 !s_q.pri[1]);
  fan_flag_c: cover property (s_q.sec[2] && irq);
  thermal_c: cover property (s_q.cfg[1] && s_q.sec[5]);
  slverr_c: cover property (s_axi_rvalid && s_axi_rresp == limit_flags_pkg::RESP_SLVERR);
  set_wins_c: cover property (rd_pri && meas_done[6] && viol_now[6]);

endmodule : monitor_limit_status_flags

// File: host_axi_model.sv
// Host bus master model issuing AXI4-Lite register accesses
`timescale 1ns/1ps
module host_axi_model (
  // Clock
  input  wire logic        clk_sys,
  // Write channels
  output logic             awvalid,
  input  wire logic        awready,
  output logic [11:0]      awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // Read channels
  output logic             arvalid,
  input  wire logic        arready,
  output logic [11:0]      araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
  end

  // Released address and data lines show the inverse of the last value
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata  <= d;
    wstrb  <= 4'hF;
    while (!done)
    begin
      @(posedge clk_sys);
      if (awvalid && awready) awaddr <= ~a;
      if (wvalid && wready) wdata <= ~d;
      awvalid <= awvalid && !awready;
      wvalid  <= wvalid && !wready;
      done = bvalid;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do
    begin
      @(posedge clk_sys);
      if (arvalid && arready) araddr <= ~a;
      arvalid <= arvalid && !arready;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read
endmodule : host_axi_model

// File: monitor_limit_status_flags_test.sv
// Self-checking bench for the latched limit status flags
`timescale 1ns/1ps
module monitor_limit_status_flags_test;
  localparam logic [11:0] PRI = limit_flags_pkg::ADDR_PRIMARY;
  localparam logic [11:0] SEC = limit_flags_pkg::ADDR_SECONDARY;
  localparam logic [11:0] IST = limit_flags_pkg::ADDR_IRQ_STAT;
  localparam logic [11:0] MSK = limit_flags_pkg::ADDR_IRQ_MASK;
  localparam logic [1:0]  OK  = limit_flags_pkg::RESP_OKAY;
  logic            clk_sys = 1'b0;
  logic            sys_rst = 1'b1;
  logic [7:0]      done = 8'h00;
  logic [7:0][7:0] m_rd = '0;
  logic [7:0][7:0] m_lo = {{3{8'hF0}}, {5{8'h10}}};
  logic [7:0][7:0] m_hi = {{3{8'h20}}, {5{8'hE0}}};
  logic [3:0]      tach = 4'h0;
  logic [2:0]      drv_off = 3'h0;
  logic            thermal = 1'b0;
  logic [1:0]      diode = 2'h0;
  logic            tert = 1'b0;
  logic            awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, irq;
  logic [11:0]     awa, ara;
  logic [31:0]     wd, rdat, d;
  logic [3:0]      ws;
  logic [1:0]      bresp, rresp, r;
  int              num_errors = 0;
  int              compares = 0;
  int              cycles = 0;

  always #4 clk_sys = ~clk_sys;

  monitor_limit_status_flags #(.DATA_W(8)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .meas_done(done), .meas_reading(m_rd), .limit_low(m_lo), .limit_high(m_hi),
    .tach_slow(tach), .fan_drive_off(drv_off), .thermal_timer_over(thermal), .diode_fault(diode),
    .tertiary_any(tert), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .irq(irq));

  host_axi_model host (.clk_sys(clk_sys), .awvalid(awv), .awready(awr), .awaddr(awa),
    .wvalid(wv), .wready(wr_rdy), .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(br),
    .bresp(bresp), .arvalid(arv), .arready(arr), .araddr(ara), .rvalid(rv), .rready(rr),
    .rdata(rdat), .rresp(rresp));

  task automatic end_of_test;
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    host.axi_read(a, d, r);
    check({30'h0, r}, {30'h0, OK});
    check(d, exp);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] exp);
    host.axi_write(a, v, r);
    check({30'h0, r}, {30'h0, exp});
  endtask : wr

  task automatic meas(input int c, input logic [7:0] v);
    @(posedge clk_sys);
    done    <= 8'h01 << c;
    m_rd[c] <= v;
    @(posedge clk_sys);
    done <= 8'h00;
  endtask : meas

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  initial
  begin
    int          b;
    logic [11:0] a;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(PRI, 32'h0);
    rd(SEC, 32'h0);
    rd(MSK, 32'h0);
    wr(PRI, 32'hFF, OK);
    rd(PRI, 32'h0);
    wr(12'h0FC, 32'h1, limit_flags_pkg::RESP_SLVERR);
    host.axi_read(12'h0FC, d, r);
    check({30'h0, r}, {30'h0, limit_flags_pkg::RESP_SLVERR});
    check(d, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      a = (c == 4) ? SEC : PRI;
      b = (c < 4) ? c : (c == 4) ? 0 : c - 1;
      meas(c, m_hi[c]);
      rd(a, 32'h0);
      meas(c, c[0] ? m_hi[c] + 8'h01 : m_lo[c]);
      rd(a, 32'h1 << b);
      if (c == 4) rd(PRI, 32'h80);
      meas(c, (c < 5) ? 8'h80 : 8'hFF);
      rd(a, 32'h1 << b);
      rd(a, 32'h0);
    end
    // A new violation arriving with a clearing read keeps the bit
    meas(6, m_lo[6]);
    meas(6, 8'hFF);
    fork
      host.axi_read(PRI, d, r);
      meas(6, m_lo[6]);
    join
    check(d, 32'h20);
    meas(6, 8'hFF);
    rd(PRI, 32'h20);
    rd(PRI, 32'h0);
    wr(limit_flags_pkg::ADDR_CONFIG, 32'h1, OK);
    @(posedge clk_sys);
    thermal <= 1'b1;
    rd(PRI, 32'h01);
    wr(limit_flags_pkg::ADDR_CONFIG, 32'h3, OK);
    rd(SEC, 32'h20);
    rd(PRI, 32'h81);
    @(posedge clk_sys);
    thermal <= 1'b0;
    wr(limit_flags_pkg::ADDR_CONFIG, 32'h0, OK);
    rd(SEC, 32'h20);
    rd(SEC, 32'h0);
    rd(PRI, 32'h01);
    rd(PRI, 32'h0);
    for (int f = 0; f < 4; f++)
    begin
      @(posedge clk_sys);
      drv_off <= 3'h1 << ((f == 3) ? 2 : f);
      tach    <= 4'h1 << f;
      rd(SEC, 32'h0);
      @(posedge clk_sys);
      drv_off <= 3'h0;
      rd(SEC, 32'h4 << f);
      @(posedge clk_sys);
      tach <= 4'h0;
      rd(SEC, 32'h4 << f);
      rd(SEC, 32'h0);
    end
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_sys);
      {tert, diode} <= 3'h1 << k;
      rd(SEC, (k == 2) ? 32'h2 : 32'h40 << k);
      @(posedge clk_sys);
      {tert, diode} <= 3'h0;
      rd(SEC, (k == 2) ? 32'h0 : 32'h40 << k);
      rd(SEC, 32'h0);
    end
    // Interrupt: raise, mask, clear
    wr(IST, 32'hFFFF, OK);
    rd(IST, 32'h0);
    @(posedge clk_sys);
    diode <= 2'h1;
    rd(IST, 32'h4000);
    check({31'h0, irq}, 32'h0);
    wr(MSK, 32'h4000, OK);
    check({31'h0, irq}, 32'h1);
    rd(MSK, 32'h4000);
    wr(IST, 32'h4000, OK);
    check({31'h0, irq}, 32'h0);
    rd(IST, 32'h0);
    end_of_test();
  end
endmodule : monitor_limit_status_flags_test
